/* hdl/uart_core.sv */
// serial transceiver with queues, framing, flow control and dma requests
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - bit timing from a programmable clock divider, up to 3 Mbps
// - bit clock derived from the system clock only
// - separate transmit and receive queues of sixteen bytes
// - software may select single-entry queue mode
// - thresholds 1/8, 1/4, 1/2, 3/4, 7/8 for interrupts and bursts
// - start bit, optional parity, one or more stop bits per character
// - five to eight data bits per character
// - parity even, odd, stick or none, generated and checked
// - transmitter sends one or two stop bits
// - break can be sent and a received break is detected
// - rts/cts handshaking in both directions
// - interrupts on threshold crossing and end of transmission
// - separate dma channels for transmit and receive
// - receive single request when data, burst at fill level
// - transmit single request when space, burst at fill level
module uart_core
   import uart_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // configuration
   input wire logic [DIV_W-1:0] divisor_i,
   input wire logic [1:0] char_len_i,
   input wire logic [1:0] parity_i,
   input wire logic stick_val_i,
   input wire logic two_stop_i,
   input wire logic send_break_i,
   input wire logic single_i,
   input wire logic [2:0] tx_trig_i,
   input wire logic [2:0] rx_trig_i,
   input wire logic flow_en_i,
   input wire logic flush_i,
   // transmit data from the processor or dma
   input wire logic tx_valid_i,
   input wire logic [DATA_W-1:0] tx_data_i,
   output logic tx_ready_o,
   // received data to the processor or dma
   output logic rx_valid_o,
   output logic [DATA_W-1:0] rx_data_o,
   input wire logic rx_ready_i,
   // received character status
   output logic parity_err_o,
   output logic frame_err_o,
   output logic break_det_o,
   output logic overrun_o,
   // serial line
   output logic txd_o,
   input wire logic rxd_i,
   output logic rts_n_o,
   input wire logic cts_n_i,
   // interrupt conditions
   output logic tx_level_irq_o,
   output logic rx_level_irq_o,
   output logic tx_done_irq_o,
   // dma requests
   output logic tx_dma_single_o,
   output logic tx_dma_burst_o,
   output logic rx_dma_single_o,
   output logic rx_dma_burst_o,
   // status
   output logic busy_o,
   output logic [CNT_W-1:0] tx_level_o,
   output logic [CNT_W-1:0] rx_level_o
);
   typedef struct packed {
      logic [1:0] rxd_sync;
      logic [1:0] cts_sync;
      tx_state_type tx_st;
      logic [3:0] tx_tick;
      logic [3:0] tx_bits;
      logic [DATA_W-1:0] tx_shift;
      logic tx_par;
      logic tx_stop2;
      logic txd;
      logic tx_done;
      rx_state_type rx_st;
      logic [3:0] rx_tick;
      logic [3:0] rx_bits;
      logic [DATA_W-1:0] rx_shift;
      logic rx_par;
      logic rx_perr;
      logic parity_err;
      logic frame_err;
      logic break_det;
      logic overrun;
      logic rts_n;
      logic tx_lvl_irq;
      logic rx_lvl_irq;
   } core_state_type;

   core_state_type state_reg;
   core_state_type state_next;
   logic tick;
   logic tx_pop;
   logic tx_avail;
   logic [DATA_W-1:0] tx_head;
   logic rx_push;
   logic rx_space;
   logic [CNT_W-1:0] tx_lvl;
   logic [CNT_W-1:0] rx_lvl;
   logic [CNT_W-1:0] tx_thr;
   logic [CNT_W-1:0] rx_thr;
   logic [3:0] nbits;
   logic rxd;
   logic cts_ok;

   uart_baud baud_u (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .divisor_i(divisor_i),
      .tick_o(tick)
   );

   uart_fifo tx_fifo_u (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .single_i(single_i),
      .flush_i(flush_i),
      .wr_valid_i(tx_valid_i),
      .wr_data_i(tx_data_i),
      .wr_ready_o(tx_ready_o),
      .rd_valid_o(tx_avail),
      .rd_data_o(tx_head),
      .rd_ready_i(tx_pop),
      .level_o(tx_lvl)
   );

   uart_fifo rx_fifo_u (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .single_i(single_i),
      .flush_i(flush_i),
      .wr_valid_i(rx_push),
      .wr_data_i(state_reg.rx_shift),
      .wr_ready_o(rx_space),
      .rd_valid_o(rx_valid_o),
      .rd_data_o(rx_data_o),
      .rd_ready_i(rx_ready_i),
      .level_o(rx_lvl)
   );

   assign nbits = {2'h0, char_len_i} + 4'h5;
   assign rxd = state_reg.rxd_sync[1];
   assign cts_ok = !flow_en_i || !state_reg.cts_sync[1];
   assign tx_thr = trig_level(tx_trig_i, single_i);
   assign rx_thr = trig_level(rx_trig_i, single_i);
   // a frame is only started at a tick so its first bit is full length
   assign tx_pop = tick && (state_reg.tx_st == TX_IDLE) && tx_avail && cts_ok
                   && !send_break_i;

   always_comb begin
      state_next = state_reg;
      rx_push = 1'b0;
      state_next.rxd_sync = {state_reg.rxd_sync[0], rxd_i};
      state_next.cts_sync = {state_reg.cts_sync[0], cts_n_i};
      state_next.tx_done = 1'b0;
      // transmitter
      if (tick) begin
         case (state_reg.tx_st)
            TX_IDLE: begin
               if (tx_pop) begin
                  state_next.tx_st = TX_START;
                  state_next.tx_shift = tx_head;
                  state_next.tx_par = 1'b0;
                  state_next.tx_stop2 = two_stop_i;
                  state_next.tx_tick = TICK_RESET;
                  state_next.txd = 1'b0;
               end
            end
            TX_START: begin
               state_next.tx_tick = state_reg.tx_tick + 4'h1;
               if (state_reg.tx_tick == 4'hF) begin
                  state_next.tx_st = TX_DATA;
                  state_next.tx_bits = BIT_CNT_RESET;
                  state_next.txd = state_reg.tx_shift[0];
               end
            end
            TX_DATA: begin
               state_next.tx_tick = state_reg.tx_tick + 4'h1;
               if (state_reg.tx_tick == 4'hF) begin
                  state_next.tx_par = state_reg.tx_par ^ state_reg.tx_shift[0];
                  state_next.tx_shift = {1'b0, state_reg.tx_shift[DATA_W-1:1]};
                  state_next.tx_bits = state_reg.tx_bits + 4'h1;
                  state_next.txd = state_reg.tx_shift[1];
                  if (state_reg.tx_bits == nbits - 4'h1) begin
                     if (parity_i == PAR_NONE) begin
                        state_next.tx_st = TX_STOP;
                        state_next.txd = 1'b1;
                     end else begin
                        state_next.tx_st = TX_PAR;
                        case (parity_i)
                           PAR_EVEN: state_next.txd = state_next.tx_par;
                           PAR_ODD: state_next.txd = !state_next.tx_par;
                           default: state_next.txd = stick_val_i;
                        endcase
                     end
                  end
               end
            end
            TX_PAR: begin
               state_next.tx_tick = state_reg.tx_tick + 4'h1;
               if (state_reg.tx_tick == 4'hF) begin
                  state_next.tx_st = TX_STOP;
                  state_next.txd = 1'b1;
               end
            end
            TX_STOP: begin
               state_next.tx_tick = state_reg.tx_tick + 4'h1;
               if (state_reg.tx_tick == 4'hF) begin
                  if (state_reg.tx_stop2) begin
                     state_next.tx_stop2 = 1'b0;
                  end else begin
                     state_next.tx_st = TX_IDLE;
                     state_next.tx_done = !tx_avail;
                  end
               end
            end
            default: state_next.tx_st = TX_IDLE;
         endcase
      end
      // receiver
      if (tick) begin
         case (state_reg.rx_st)
            RX_IDLE: begin
               if (!rxd) begin
                  state_next.rx_st = RX_START;
                  state_next.rx_tick = TICK_RESET;
               end
            end
            RX_START: begin
               state_next.rx_tick = state_reg.rx_tick + 4'h1;
               if (state_reg.rx_tick == 4'(OVS_HALF - 1)) begin
                  // a glitch shorter than half a bit is dropped
                  if (rxd) begin
                     state_next.rx_st = RX_IDLE;
                  end else begin
                     state_next.rx_st = RX_DATA;
                     state_next.rx_tick = TICK_RESET;
                     state_next.rx_bits = BIT_CNT_RESET;
                     state_next.rx_shift = '0;
                     state_next.rx_par = 1'b0;
                     state_next.rx_perr = 1'b0;
                  end
               end
            end
            RX_DATA: begin
               state_next.rx_tick = state_reg.rx_tick + 4'h1;
               if (state_reg.rx_tick == 4'hF) begin
                  // mid-bit sample; lsb first, each bit written straight to its own index, no shift
                  state_next.rx_shift[state_reg.rx_bits[2:0]] = rxd;
                  state_next.rx_par = state_reg.rx_par ^ rxd;
                  state_next.rx_bits = state_reg.rx_bits + 4'h1;
                  if (state_reg.rx_bits == nbits - 4'h1) begin
                     state_next.rx_st = (parity_i == PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end
            end
            RX_PAR: begin
               state_next.rx_tick = state_reg.rx_tick + 4'h1;
               if (state_reg.rx_tick == 4'hF) begin
                  state_next.rx_st = RX_STOP;
                  case (parity_i)
                     PAR_EVEN: state_next.rx_perr = state_reg.rx_par ^ rxd;
                     PAR_ODD: state_next.rx_perr = !(state_reg.rx_par ^ rxd);
                     default: state_next.rx_perr = (rxd != stick_val_i);
                  endcase
                  state_next.rx_par = state_reg.rx_par | rxd;
               end
            end
            RX_STOP: begin
               state_next.rx_tick = state_reg.rx_tick + 4'h1;
               if (state_reg.rx_tick == 4'hF) begin
                  state_next.rx_st = RX_IDLE;
                  // only the first stop bit is checked
                  state_next.frame_err = !rxd;
                  state_next.parity_err = state_reg.rx_perr;
                  state_next.break_det = !rxd && (state_reg.rx_shift == '0)
                     && (parity_i == PAR_NONE || !state_reg.rx_par);
                  state_next.overrun = !rx_space;
                  rx_push = rx_space;
               end
            end
            default: state_next.rx_st = RX_IDLE;
         endcase
      end
      // rts deasserts when the receive queue is at its threshold
      state_next.rts_n = flow_en_i && (rx_lvl >= rx_thr);
      state_next.tx_lvl_irq = (tx_lvl <= tx_thr);
      state_next.rx_lvl_irq = (rx_lvl >= rx_thr);
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.rxd_sync <= 2'h3;
         state_reg.tx_st <= TX_IDLE;
         state_reg.rx_st <= RX_IDLE;
         state_reg.txd <= 1'b1;
         state_reg.rts_n <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign txd_o = state_reg.txd && !send_break_i;
   assign rts_n_o = state_reg.rts_n;
   assign parity_err_o = state_reg.parity_err;
   assign frame_err_o = state_reg.frame_err;
   assign break_det_o = state_reg.break_det;
   assign overrun_o = state_reg.overrun;
   assign tx_level_irq_o = state_reg.tx_lvl_irq;
   assign rx_level_irq_o = state_reg.rx_lvl_irq;
   assign tx_done_irq_o = state_reg.tx_done;
   assign tx_dma_single_o = tx_ready_o;
   assign tx_dma_burst_o = state_reg.tx_lvl_irq;
   assign rx_dma_single_o = rx_valid_o;
   assign rx_dma_burst_o = state_reg.rx_lvl_irq;
   assign busy_o = (state_reg.tx_st != TX_IDLE) || tx_avail;
   assign tx_level_o = tx_lvl;
   assign rx_level_o = rx_lvl;
endmodule
`default_nettype wire

/* common/uart_pkg.sv */
// constants and types shared by the serial transceiver
package uart_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam int DIV_W = 16;
   localparam int OVS = 16;
   localparam int OVS_HALF = 8;
   localparam int CLK_HZ = 50000000;
   localparam int MAX_BPS = 3000000;
   // fastest rate at 16x oversampling: one tick per two clocks floor
   localparam int MIN_DIV = 1;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h001B;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;
   localparam logic [3:0] TICK_RESET = 4'h0;
   localparam logic [CNT_W-1:0] LEVEL_RESET = 5'h00;
   localparam logic [1:0] LEN_5 = 2'h0;
   localparam logic [1:0] LEN_8 = 2'h3;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [1:0] PAR_STICK = 2'h3;
   localparam logic [2:0] TRIG_1_8 = 3'h0;
   localparam logic [2:0] TRIG_1_4 = 3'h1;
   localparam logic [2:0] TRIG_1_2 = 3'h2;
   localparam logic [2:0] TRIG_3_4 = 3'h3;
   localparam logic [2:0] TRIG_7_8 = 3'h4;

   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA = 5'b00100,
      TX_PAR = 5'b01000,
      TX_STOP = 5'b10000
   } tx_state_type;

   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001,
      RX_START = 5'b00010,
      RX_DATA = 5'b00100,
      RX_PAR = 5'b01000,
      RX_STOP = 5'b10000
   } rx_state_type;

   // trigger level in entries for a fifo of the given depth
   function automatic logic [CNT_W-1:0] trig_level(input logic [2:0] sel,
                                                   input logic single);
      logic [CNT_W-1:0] lvl;
      lvl = 5'h02;
      case (sel)
         TRIG_1_8: lvl = 5'h02;
         TRIG_1_4: lvl = 5'h04;
         TRIG_1_2: lvl = 5'h08;
         TRIG_3_4: lvl = 5'h0C;
         default: lvl = 5'h0E;
      endcase
      if (single) begin
         lvl = 5'h01;
      end
      return lvl;
   endfunction
endpackage

/* hdl/uart_fifo.sv */
// sixteen-entry byte queue with a selectable single-entry mode
`timescale 1ns/1ps
`default_nettype none
module uart_fifo
   import uart_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // configuration
   input wire logic single_i,
   input wire logic flush_i,
   // write side
   input wire logic wr_valid_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   output logic wr_ready_o,
   // read side
   output logic rd_valid_o,
   output logic [DATA_W-1:0] rd_data_o,
   input wire logic rd_ready_i,
   // fill level
   output logic [CNT_W-1:0] level_o
);
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [CNT_W-1:0] count;
   } fifo_state_type;

   fifo_state_type state_reg;
   fifo_state_type state_next;
   logic [CNT_W-1:0] cap;
   logic do_wr;
   logic do_rd;

   // single mode behaves as a one-deep holding register
   assign cap = single_i ? 5'h01 : 5'h10;
   assign wr_ready_o = (state_reg.count < cap);
   assign rd_valid_o = (state_reg.count != LEVEL_RESET);
   assign rd_data_o = state_reg.mem[state_reg.rd_ptr];
   assign level_o = state_reg.count;
   assign do_wr = wr_valid_i && wr_ready_o;
   assign do_rd = rd_ready_i && rd_valid_o;

   always_comb begin
      state_next = state_reg;
      if (do_wr) begin
         state_next.mem[state_reg.wr_ptr] = wr_data_i;
         state_next.wr_ptr = state_reg.wr_ptr + 4'h1;
      end
      if (do_rd) begin
         state_next.rd_ptr = state_reg.rd_ptr + 4'h1;
      end
      if (do_wr && !do_rd) begin
         state_next.count = state_reg.count + 5'h01;
      end else if (do_rd && !do_wr) begin
         state_next.count = state_reg.count - 5'h01;
      end
      if (flush_i) begin
         state_next.wr_ptr = 4'h0;
         state_next.rd_ptr = 4'h0;
         state_next.count = LEVEL_RESET;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule
`default_nettype wire

/* hdl/uart_baud.sv */
// programmable divider giving the 16x oversampling tick
`timescale 1ns/1ps
`default_nettype none
module uart_baud
   import uart_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // divisor, ticks every divisor+1 clocks
   input wire logic [DIV_W-1:0] divisor_i,
   output logic tick_o
);
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic tick;
   } baud_state_type;

   baud_state_type state_reg;
   baud_state_type state_next;

   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (state_reg.cnt >= divisor_i) begin
         state_next.cnt = '0;
         state_next.tick = 1'b1;
      end else begin
         state_next.cnt = state_reg.cnt + 16'h0001;
      end
   end

   assign tick_o = state_reg.tick;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule
`default_nettype wire

/* sim/uart_core_props.sv */
// assertion checker for the serial transceiver ports
`timescale 1ns/1ps
`default_nettype none
module uart_core_props
   import uart_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // configuration
   input wire logic [1:0] char_len_i,
   input wire logic send_break_i,
   input wire logic single_i,
   input wire logic [2:0] tx_trig_i,
   input wire logic [2:0] rx_trig_i,
   input wire logic flow_en_i,
   // observed outputs
   input wire logic rx_valid_o,
   input wire logic [DATA_W-1:0] rx_data_o,
   input wire logic txd_o,
   input wire logic rts_n_o,
   input wire logic tx_level_irq_o,
   input wire logic rx_level_irq_o,
   input wire logic tx_done_irq_o,
   input wire logic tx_dma_single_o,
   input wire logic tx_dma_burst_o,
   input wire logic rx_dma_single_o,
   input wire logic rx_dma_burst_o,
   input wire logic break_det_o,
   input wire logic [CNT_W-1:0] tx_level_o,
   input wire logic [CNT_W-1:0] rx_level_o
);
   logic [CNT_W-1:0] tthr;
   logic [CNT_W-1:0] rthr;
   logic [CNT_W-1:0] cap;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // 2, 4, 8 entries by doubling, then 12 and 14
   assign tthr = single_i ? 5'h01 : (tx_trig_i < 3'h3) ? 5'h02 << tx_trig_i
      : (tx_trig_i == 3'h3) ? 5'h0C : 5'h0E;
   assign rthr = single_i ? 5'h01 : (rx_trig_i < 3'h3) ? 5'h02 << rx_trig_i
      : (rx_trig_i == 3'h3) ? 5'h0C : 5'h0E;
   assign cap = single_i ? 5'h01 : 5'h10;
   chk_reset_idle: assert property ($fell(rst_i) |-> txd_o && rts_n_o)
      else $error("idle pins wrong");
   chk_break_low: assert property (send_break_i && $past(send_break_i) |-> !txd_o)
      else $error("break not driven low");
   chk_tx_space: assert property (tx_dma_single_o == (tx_level_o < cap))
      else $error("tx single wrong");
   chk_rx_data_req: assert property (rx_dma_single_o == (rx_level_o != 5'h00))
      else $error("rx single wrong");
   chk_tx_thresh: assert property (!$past(rst_i) && $stable(tx_level_o) &&
      $stable(tx_trig_i) && $stable(single_i) |-> tx_level_irq_o == (tx_level_o <= tthr))
      else $error("tx irq wrong");
   chk_rx_thresh: assert property (!$past(rst_i) && $stable(rx_level_o) &&
      $stable(rx_trig_i) && $stable(single_i) |-> rx_level_irq_o == (rx_level_o >= rthr))
      else $error("rx irq wrong");
   chk_burst_pair: assert property (tx_dma_burst_o == tx_level_irq_o &&
      rx_dma_burst_o == rx_level_irq_o)
      else $error("burst wrong");
   chk_rts_flow: assert property (!$past(rst_i) && $stable(rx_level_o) &&
      $stable(flow_en_i) && $stable(rx_trig_i) && $stable(single_i)
      |-> rts_n_o == (flow_en_i && rx_level_o >= rthr))
      else $error("rts wrong");
   chk_done_pulse: assert property (tx_done_irq_o |-> txd_o && tx_level_o == 5'h00
      ##1 !tx_done_irq_o)
      else $error("done pulse wrong");
   chk_rx_upper: assert property (rx_valid_o && char_len_i == LEN_5 |-> rx_data_o[7:5] == 3'h0)
      else $error("rx upper bits");
   cover property ($rose(tx_done_irq_o));
   cover property ($rose(rx_dma_burst_o));
   cover property (!tx_dma_single_o);
   cover property ($rose(break_det_o));
endmodule
bind uart_core uart_core_props uart_core_props_inst (.*);
`default_nettype wire

/* sim/serial_peer.sv */
// far-end serial transceiver model with rts/cts pacing
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
   parameter int BIT_CYC = 32
) (
   // clock
   input wire logic clk_i,
   // line
   input wire logic txd_i,
   output logic rxd_o,
   input wire logic rts_n_i,
   output logic cts_n_o,
   // bench control
   input wire logic hold_i,
   input wire logic go_i,
   input wire logic [11:0] frame_i,
   input wire logic [3:0] nsend_i,
   input wire logic [3:0] nrx_i,
   output logic busy_o,
   output logic got_o,
   output logic [11:0] got_bits_o
);
   logic [11:0] fr;
   logic [11:0] bits;
   assign cts_n_o = hold_i;
   initial begin
      rxd_o = 1'b1;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            busy_o <= 1'b1;
            fr = frame_i;
            // never start into a receiver that says it is full
            while (rts_n_i) @(posedge clk_i);
            for (int i = 0; i < nsend_i; i++) begin
               rxd_o <= fr[i];
               repeat (BIT_CYC) @(posedge clk_i);
            end
            rxd_o <= 1'b1;
            busy_o <= 1'b0;
         end
      end
   end
   initial begin
      got_o = 1'b0;
      got_bits_o = 12'h000;
      forever begin
         @(posedge clk_i);
         got_o <= 1'b0;
         if (!txd_i) begin
            bits = 12'h000;
            // mid-bit sampling, start bit kept in bit 0
            repeat (BIT_CYC / 2) @(posedge clk_i);
            for (int i = 0; i < nrx_i; i++) begin
               bits[i] = txd_i;
               if (i < nrx_i - 1) repeat (BIT_CYC) @(posedge clk_i);
            end
            got_bits_o <= bits;
            got_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/test_uart_core.sv */
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module test_uart_core
   import uart_pkg::*;
;
   localparam int BIT_CYC = 32;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] divisor_i = 16'h0001;
   logic [1:0] char_len_i = LEN_8;
   logic [1:0] parity_i = PAR_NONE;
   logic stick_val_i = 1'b0, two_stop_i = 1'b0, send_break_i = 1'b0, single_i = 1'b0;
   logic [2:0] tx_trig_i = TRIG_1_2, rx_trig_i = TRIG_1_2;
   logic flow_en_i = 1'b0, flush_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic tx_ready_o, rx_valid_o, parity_err_o, frame_err_o, break_det_o, overrun_o;
   logic [7:0] rx_data_o;
   logic txd_o, rxd_i, rts_n_o, cts_n_i, tx_level_irq_o, rx_level_irq_o, tx_done_irq_o;
   logic tx_dma_single_o, tx_dma_burst_o, rx_dma_single_o, rx_dma_burst_o, busy_o;
   logic [4:0] tx_level_o, rx_level_o;
   logic hold = 1'b0, go = 1'b0, busy_p, got, hold_rx = 1'b0, ign_tx = 1'b0;
   logic [11:0] frame_v = 12'h000, got_bits;
   logic [3:0] nsend = 4'h0, nrx = 4'hA;
   logic [11:0] tx_q[$];
   logic [7:0] rx_q[$];
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   uart_core uart_core_inst (.*);
   serial_peer #(.BIT_CYC(BIT_CYC)) serial_peer_inst (.clk_i(core_clk_i), .txd_i(txd_o),
      .rxd_o(rxd_i), .rts_n_i(rts_n_o), .cts_n_o(cts_n_i), .hold_i(hold), .go_i(go),
      .frame_i(frame_v), .nsend_i(nsend), .nrx_i(nrx), .busy_o(busy_p), .got_o(got),
      .got_bits_o(got_bits));
   initial forever #10 core_clk_i = !core_clk_i;
   task automatic conclude();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [11:0] g, input logic [11:0] e, input string what);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask
   function automatic logic [7:0] msk();
      return 8'hFF >> (2'h3 - char_len_i);
   endfunction
   // expected line bits, start bit in bit 0
   function automatic logic [11:0] frame(input logic [7:0] d, output int n);
      logic [11:0] f;
      logic p;
      f = 12'h000;
      p = ^(d & msk());
      for (int k = 0; k < 5 + char_len_i; k++) f[1 + k] = d[k];
      n = 6 + char_len_i;
      if (parity_i != PAR_NONE) begin
         f[n] = (parity_i == PAR_EVEN) ? p : (parity_i == PAR_ODD) ? !p : stick_val_i;
         n++;
      end
      f[n] = 1'b1;
      f[n + 1] = two_stop_i;
      n = n + 1 + int'(two_stop_i);
      return f;
   endfunction
   task automatic burst(input int cnt);
      logic [7:0] d;
      int n;
      for (int k = 0; k < cnt; k++) begin
         d = 8'($urandom);
         tx_q.push_back(frame(d, n));
         nrx = 4'(n);
         tx_data_i = d;
         tx_valid_i = 1'b1;
         @(negedge core_clk_i);
      end
      tx_valid_i = 1'b0;
   endtask
   // mode 0 clean, 1 parity flipped, 2 line held low as a break
   task automatic send(input int mode);
      logic [7:0] d;
      int n;
      d = 8'($urandom);
      frame_v = frame(d, n);
      if (mode == 1) frame_v[6 + char_len_i] = !frame_v[6 + char_len_i];
      if (mode == 2) frame_v = 12'h000;
      if (mode != 2) rx_q.push_back(d & msk());
      nsend = (mode == 2) ? 4'hB : 4'(n);
      go = 1'b1;
      @(negedge core_clk_i);
      go = 1'b0;
      @(negedge core_clk_i);
      while (busy_p) @(negedge core_clk_i);
   endtask
   task automatic settle();
      int k;
      k = 0;
      while ((busy_o || busy_p || tx_q.size() != 0 || rx_q.size() != 0) && k++ < 20000)
         @(negedge core_clk_i);
      cmp(12'(k <= 20000), 12'h001, "stuck");
      repeat (2 * BIT_CYC) @(negedge core_clk_i);
   endtask
   always @(negedge core_clk_i) begin
      if (got && !ign_tx) begin
         if (tx_q.size() == 0) cmp(12'h001, 12'h000, "stray frame");
         else cmp(got_bits, tx_q.pop_front(), "tx frame");
      end
      if (rx_valid_o && !hold_rx) begin
         if (rx_q.size() == 0) cmp(12'h001, 12'h000, "stray byte");
         else cmp(12'(rx_data_o), 12'(rx_q.pop_front()), "rx byte");
      end
      rx_ready_i = rx_valid_o && !hold_rx;
   end
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         $display("BAD %0t run too long", $time);
         conclude();
      end
   end
   initial begin
      int rnd;
      rnd = $urandom(32'hA0DBB23F);
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      cmp({8'h0, txd_o, rts_n_o, tx_ready_o, rx_valid_o}, 12'h00E, "reset pins");
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         char_len_i = 2'(i);
         parity_i = 2'(i + i / 4);
         two_stop_i = i[2];
         stick_val_i = 1'($urandom);
         @(negedge core_clk_i);
         burst(1);
         settle();
         send(0);
         settle();
         cmp(12'(parity_err_o), 12'h000, "parity clean");
         if (parity_i != PAR_NONE) begin
            send(1);
            settle();
            cmp(12'(parity_err_o), 12'h001, "parity flip");
         end
      end
      $display("framing test done");
      char_len_i = LEN_8;
      parity_i = PAR_NONE;
      two_stop_i = 1'b0;
      flow_en_i = 1'b1;
      hold = 1'b1;
      repeat (4) @(negedge core_clk_i);
      burst(16);
      cmp(12'(tx_level_o), 12'h010, "tx full level");
      cmp(12'({tx_ready_o, txd_o}), 12'h001, "tx refuse and pause");
      hold = 1'b0;
      settle();
      $display("tx fill test done");
      hold_rx = 1'b1;
      rx_trig_i = TRIG_7_8;
      for (int k = 0; k < 14; k++) begin
         send(0);
         cmp(12'({rx_dma_burst_o, rts_n_o}), (k == 13) ? 12'h003 : 12'h000, "rx level");
      end
      hold_rx = 1'b0;
      settle();
      $display("rx fill test done");
      single_i = 1'b1;
      hold = 1'b1;
      @(negedge core_clk_i);
      burst(1);
      cmp(12'({tx_ready_o, tx_dma_single_o}), 12'h000, "single full");
      hold = 1'b0;
      settle();
      single_i = 1'b0;
      $display("single test done");
      ign_tx = 1'b1;
      send_break_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      cmp(12'(txd_o), 12'h000, "break out");
      repeat (12 * BIT_CYC) @(negedge core_clk_i);
      send_break_i = 1'b0;
      repeat (14 * BIT_CYC) @(negedge core_clk_i);
      ign_tx = 1'b0;
      hold_rx = 1'b1;
      send(2);
      cmp(12'(break_det_o), 12'h001, "break seen");
      flush_i = 1'b1;
      @(negedge core_clk_i);
      flush_i = 1'b0;
      hold_rx = 1'b0;
      @(negedge core_clk_i);
      cmp(12'(rx_level_o), 12'h000, "flushed");
      $display("break test done");
      conclude();
   end
endmodule
`default_nettype wire
